// ---- obcd_option_decoder.sv ----
// Option byte decoder: latches both option bytes after power-on reset,
// times the reset and halt-exit phases and drives the decoded settings.
// Assumes option bytes are stable while reset_n is low and shortly after.
`timescale 1ns/1ps
`default_nettype none
`include "obcd_defs.svh"
module obcd_option_decoder
  import obcd_pkg::*;
#(
  parameter int          PAD_PORTS    = 6,
  parameter int          RST_LONG     = `OBCD_RST_LONG,
  parameter int          RST_SHORT    = `OBCD_RST_SHORT,
  // Pads without a pin on the 44-pin package; value is arbitrary
  parameter logic [47:0] UNBONDED_44  = 48'h0000_F000_00F0
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Non-volatile option content
  input  wire logic [7:0]             opt_byte0,
  input  wire logic [7:0]             opt_byte1,
  input  wire logic                   opt_erased,
  // Core events
  input  wire logic                   halt_entry,
  input  wire logic                   halt_wake,
  input  wire logic                   option_erase_req,
  input  wire logic                   user_erase_done,
  // Register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [7:0]                  reg_rdata,
  // Reset and sequencing
  output logic                        core_reset_n,
  output logic                        core_stall,
  output logic                        user_erase_start,
  output logic                        option_erase_grant,
  // Decoded settings
  output logic                        wdog_enable,
  output logic                        wdog_halt_reset_sel,
  output logic                        clock_guard_enable,
  output logic                        low_supply_detector,
  output logic                        aux_supply_detector,
  output logic [1:0]                  voltage_detect_sel,
  output logic                        readout_block,
  output logic                        flash_write_block,
  output logic                        package_is_44,
  output logic [PAD_PORTS*8-1:0]      pad_hold_pullup,
  output logic [1:0]                  clock_source_type,
  output logic [2:0]                  oscillator_range_sel,
  output logic                        range_low_power,
  output logic                        range_medium_power,
  output logic                        range_medium_speed,
  output logic                        range_high_speed,
  output logic                        doubler_enable,
  output logic                        config_warning
);
  localparam int TW = 13;

  typedef struct packed {
    obcd_phase_e phase;
    logic [7:0]  byte0;
    logic [7:0]  byte1;
    logic        wdog_sw_en;
    logic        halt_rst_flag;
    logic        erase_start;
    logic        erase_grant;
    logic [7:0]  rdata;
  } obcd_state_s;

  obcd_state_s st;
  obcd_state_s next_st;
  logic        tmr_start;
  logic        tmr_busy;
  logic        tmr_done;
  logic [TW-1:0] tmr_len;

  initial begin
    if (RST_LONG < 2 || RST_LONG >= (1 << TW)) $error("RST_LONG out of range");
    if (RST_SHORT < 2 || RST_SHORT > RST_LONG) $error("RST_SHORT out of range");
    if (PAD_PORTS < 1 || PAD_PORTS > 6) $error("PAD_PORTS out of range");
  end

  function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                          input obcd_state_s s,
                                          input logic [7:0] status);
    case (addr)
      `OBCD_REG_OPT0:   read_reg = s.byte0;
      `OBCD_REG_OPT1:   read_reg = s.byte1;
      `OBCD_REG_STATUS: read_reg = status;
      `OBCD_REG_CTRL:   read_reg = {7'h00, s.wdog_sw_en};
      default:          read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // Decode from latched bytes only, so settings never follow the inputs
  logic [1:0] pkg_code;
  logic       protect_on;
  logic       wdog_active;
  logic       rst_short;
  logic [7:0] status;

  assign wdog_halt_reset_sel = st.byte0[`OBCD_B0_WDOG_HALT];
  assign wdog_active = !st.byte0[`OBCD_B0_WDOG_TYPE] || st.wdog_sw_en;
  assign wdog_enable = wdog_active;
  assign clock_guard_enable = !st.byte0[`OBCD_B0_CLK_GUARD];
  assign voltage_detect_sel = st.byte0[`OBCD_B0_VD_HI:`OBCD_B0_VD_LO];
  assign low_supply_detector = (voltage_detect_sel != `OBCD_VD_OFF);
  assign aux_supply_detector = (voltage_detect_sel != `OBCD_VD_OFF);
  assign protect_on = !st.byte0[`OBCD_B0_PROTECT];
  assign readout_block = protect_on;
  assign flash_write_block = protect_on;
  assign pkg_code = {st.byte1[`OBCD_B1_PKG_HI], st.byte0[`OBCD_B0_PKG_LO]};
  assign package_is_44 = (pkg_code == `OBCD_PKG_44);
  // Unbonded pads pinned as pulled-up inputs on the small package
  assign pad_hold_pullup = package_is_44 ? UNBONDED_44[PAD_PORTS*8-1:0]
                                         : '0;
  assign clock_source_type = st.byte1[`OBCD_B1_SRC_HI:`OBCD_B1_SRC_LO];
  assign oscillator_range_sel =
    st.byte1[`OBCD_B1_RANGE_HI:`OBCD_B1_RANGE_LO];
  assign range_low_power    = (oscillator_range_sel == 3'h0);
  assign range_medium_power = (oscillator_range_sel == 3'h1);
  assign range_medium_speed = (oscillator_range_sel == 3'h2);
  assign range_high_speed   = (oscillator_range_sel == 3'h3);
  assign doubler_enable = !st.byte1[`OBCD_B1_DOUBLER];
  assign rst_short = st.byte1[`OBCD_B1_RST_LEN];

  // Combinations the chip cannot serve are only flagged, never corrected
  assign config_warning =
    (clock_source_type == `OBCD_SRC_RESERVED) ||
    (oscillator_range_sel > `OBCD_RANGE_MAX) ||
    (st.byte0[`OBCD_B0_RESERVED] != `OBCD_RESERVED_DEF) ||
    (protect_on && low_supply_detector) ||
    (doubler_enable && (oscillator_range_sel != `OBCD_RANGE_2_4MHZ)) ||
    (doubler_enable && (clock_source_type == `OBCD_SRC_INTERNAL_RC));

  assign status = {3'h0, st.phase == OBCD_ERASE, package_is_44,
                   config_warning, wdog_active, st.halt_rst_flag};

  assign tmr_len = rst_short ? TW'(RST_SHORT) : TW'(RST_LONG);

  always_comb begin
    next_st = st;
    tmr_start = 1'b0;
    next_st.erase_start = 1'b0;
    next_st.erase_grant = 1'b0;
    next_st.rdata = reg_rd ? read_reg(reg_addr, st, status) : 8'h00;
    if (reg_wr && reg_addr == `OBCD_REG_CTRL) begin
      // Software may switch the watchdog on but never off
      if (reg_wdata[`OBCD_CTRL_WDOG_EN]) next_st.wdog_sw_en = 1'b1;
      if (reg_wdata[`OBCD_CTRL_CLR_HALT]) next_st.halt_rst_flag = 1'b0;
    end
    case (st.phase)
      OBCD_LOAD: begin
        // Caught once after release; held until the next power-on reset
        next_st.byte0 = opt_erased ? `OBCD_ERASED_BYTE : opt_byte0;
        next_st.byte1 = opt_erased ? `OBCD_ERASED_BYTE : opt_byte1;
        next_st.phase = OBCD_RESET;
      end
      OBCD_RESET: begin
        if (!tmr_busy) tmr_start = 1'b1;
        if (tmr_done) next_st.phase = OBCD_RUN;
      end
      OBCD_RUN: begin
        if (halt_entry) begin
          if (wdog_active && wdog_halt_reset_sel) begin
            next_st.phase = OBCD_RESET;
            next_st.halt_rst_flag = 1'b1;
            next_st.wdog_sw_en = 1'b0;
          end else begin
            next_st.phase = OBCD_HALT;
          end
        end else if (option_erase_req) begin
          if (protect_on) begin
            next_st.phase = OBCD_ERASE;
            next_st.erase_start = 1'b1;
          end else begin
            next_st.erase_grant = 1'b1;
          end
        end
      end
      OBCD_HALT: begin
        if (halt_wake) next_st.phase = OBCD_WAKE;
      end
      OBCD_WAKE: begin
        if (!tmr_busy) tmr_start = 1'b1;
        if (tmr_done) next_st.phase = OBCD_RUN;
      end
      OBCD_ERASE: begin
        if (user_erase_done) begin
          next_st.erase_grant = 1'b1;
          next_st.phase = OBCD_RUN;
        end
      end
      default: next_st.phase = OBCD_LOAD;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{phase: OBCD_LOAD, byte0: `OBCD_ERASED_BYTE,
              byte1: `OBCD_ERASED_BYTE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  obcd_cycle_timer #(
    .W (TW)
  ) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (tmr_start),
    .length  (tmr_len),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  assign reg_rdata = st.rdata;
  assign core_reset_n = !(st.phase == OBCD_LOAD || st.phase == OBCD_RESET);
  assign core_stall = (st.phase == OBCD_HALT) || (st.phase == OBCD_WAKE);
  assign user_erase_start = st.erase_start;
  assign option_erase_grant = st.erase_grant;

  // Helper: length of each timed phase in cycles
  logic [TW:0] ph_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_cnt <= '0;
    end else if (tmr_start) begin
      ph_cnt <= (TW+1)'(1);
    end else if (tmr_busy) begin
      ph_cnt <= ph_cnt + (TW+1)'(1);
    end
  end

  chk_phase_length: assert property (@(posedge clk) disable iff (!reset_n)
    tmr_done |-> ph_cnt == (TW+1)'(rst_short ? RST_SHORT : RST_LONG))
    else $error("reset phase length wrong");
  chk_halt_reset: assert property (@(posedge clk) disable iff (!reset_n)
    (st.phase == OBCD_RUN && halt_entry && wdog_active && wdog_halt_reset_sel)
    |=> !core_reset_n && st.halt_rst_flag)
    else $error("halt did not reset core");
  chk_halt_no_reset: assert property (@(posedge clk) disable iff (!reset_n)
    (st.phase == OBCD_RUN && halt_entry && !(wdog_active && wdog_halt_reset_sel))
    |=> core_reset_n && st.phase == OBCD_HALT)
    else $error("halt reset without cause");
  chk_hw_watchdog: assert property (@(posedge clk) disable iff (!reset_n)
    !st.byte0[`OBCD_B0_WDOG_TYPE] |-> wdog_enable)
    else $error("hardware watchdog off");
  chk_guard_and_vd: assert property (@(posedge clk) disable iff (!reset_n)
    (clock_guard_enable != st.byte0[`OBCD_B0_CLK_GUARD]) &&
    (low_supply_detector == (st.byte0[4:3] != 2'h3)))
    else $error("guard or detector decode wrong");
  chk_protect_block: assert property (@(posedge clk) disable iff (!reset_n)
    readout_block == flash_write_block && readout_block == !st.byte0[0])
    else $error("protection decode wrong");
  chk_erase_order: assert property (@(posedge clk) disable iff (!reset_n)
    (st.phase == OBCD_RUN && option_erase_req && !halt_entry && protect_on)
    |=> user_erase_start && !option_erase_grant && st.phase == OBCD_ERASE)
    else $error("option erase before user erase");
  chk_erase_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (st.phase == OBCD_ERASE && !user_erase_done) |=> !option_erase_grant)
    else $error("grant during user erase");
  chk_erase_grant: assert property (@(posedge clk) disable iff (!reset_n)
    (st.phase == OBCD_ERASE && user_erase_done) |=> option_erase_grant)
    else $error("no grant after user erase");
  chk_open_grant: assert property (@(posedge clk) disable iff (!reset_n)
    (st.phase == OBCD_RUN && option_erase_req && !halt_entry && !protect_on)
    |=> option_erase_grant && !user_erase_start)
    else $error("open erase mishandled");
  chk_package: assert property (@(posedge clk) disable iff (!reset_n)
    !package_is_44 |-> pad_hold_pullup == '0)
    else $error("pads held on large package");
  chk_source_pass: assert property (@(posedge clk) disable iff (!reset_n)
    clock_source_type == st.byte1[5:4] && oscillator_range_sel == st.byte1[3:1]
    && doubler_enable != st.byte1[0])
    else $error("clock decode wrong");
  chk_latched_stable: assert property (@(posedge clk) disable iff (!reset_n)
    st.phase != OBCD_LOAD |=> $stable(st.byte0) && $stable(st.byte1))
    else $error("options changed after load");
  chk_erased_ones: assert property (@(posedge clk) disable iff (!reset_n)
    (st.phase == OBCD_LOAD && opt_erased) |=> st.byte0 == 8'hFF && st.byte1 == 8'hFF)
    else $error("erased content not all ones");

  // Sequencing and register port
  chk_load_to_reset: assert property (@(posedge clk) disable iff (!reset_n)
    st.phase == OBCD_LOAD |=> st.phase == OBCD_RESET && !core_reset_n)
    else $error("load not followed by reset");
  chk_stall_wake: assert property (@(posedge clk) disable iff (!reset_n)
    (st.phase == OBCD_HALT && halt_wake) |=> core_stall && core_reset_n)
    else $error("halt exit phase missing");
  chk_flag_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_wr && reg_addr == `OBCD_REG_CTRL && reg_wdata[`OBCD_CTRL_CLR_HALT]
     && !(st.phase == OBCD_RUN && halt_entry)) |=> !st.halt_rst_flag)
    else $error("halt flag not cleared");
  chk_sw_wdog_drop: assert property (@(posedge clk) disable iff (!reset_n)
    (st.phase == OBCD_RUN && halt_entry && wdog_active && wdog_halt_reset_sel)
    |=> !st.wdog_sw_en)
    else $error("soft watchdog kept");
  chk_sw_wdog_off: assert property (@(posedge clk) disable iff (!reset_n)
    (st.byte0[`OBCD_B0_WDOG_TYPE] && !st.wdog_sw_en) |-> !wdog_enable)
    else $error("soft watchdog on unasked");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read");
  chk_rdata_opt: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `OBCD_REG_OPT1) |=> reg_rdata == $past(st.byte1))
    else $error("option readback wrong");
  chk_status_read: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `OBCD_REG_STATUS) |=> reg_rdata[0] == $past(st.halt_rst_flag)
    && reg_rdata[1] == $past(wdog_enable) && reg_rdata[3] == $past(package_is_44))
    else $error("status readback wrong");

  // Decode checks
  chk_range_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    oscillator_range_sel > `OBCD_RANGE_MAX |-> config_warning && !(range_low_power ||
      range_medium_power || range_medium_speed || range_high_speed))
    else $error("reserved range decoded");
  chk_pads_44: assert property (@(posedge clk) disable iff (!reset_n)
    package_is_44 |-> pad_hold_pullup == UNBONDED_44[PAD_PORTS*8-1:0])
    else $error("unbonded pads not held");
  chk_doubler_warn: assert property (@(posedge clk) disable iff (!reset_n)
    (doubler_enable && clock_source_type == `OBCD_SRC_INTERNAL_RC) |-> config_warning)
    else $error("doubler misuse not flagged");

  cov_halt_reset: cover property (@(posedge clk) disable iff (!reset_n)
    st.phase == OBCD_RUN ##1 st.phase == OBCD_RESET);
  cov_halt_wake: cover property (@(posedge clk) disable iff (!reset_n)
    st.phase == OBCD_WAKE ##1 st.phase == OBCD_RUN);
  cov_erase: cover property (@(posedge clk) disable iff (!reset_n)
    user_erase_start ##[1:20] option_erase_grant);
  cov_open_grant: cover property (@(posedge clk) disable iff (!reset_n)
    option_erase_req && !protect_on ##1 option_erase_grant);
  cov_erased_load: cover property (@(posedge clk) disable iff (!reset_n)
    st.phase == OBCD_LOAD && opt_erased ##1 st.phase == OBCD_RESET);
endmodule : obcd_option_decoder
`default_nettype wire

// ---- obcd_defs.svh ----
// Offsets, field positions, reset values and timing counts of the option decoder.
// Assumes a 250 MHz clk; reset phases are counted in clk cycles.
`ifndef OBCD_DEFS_SVH
`define OBCD_DEFS_SVH

`define OBCD_ERASED_BYTE     8'hFF
`define OBCD_RESERVED_DEF    1'h1
// Byte 0 fields
`define OBCD_B0_WDOG_HALT    7
`define OBCD_B0_WDOG_TYPE    6
`define OBCD_B0_CLK_GUARD    5
`define OBCD_B0_VD_HI        4
`define OBCD_B0_VD_LO        3
`define OBCD_B0_RESERVED     2
`define OBCD_B0_PKG_LO       1
`define OBCD_B0_PROTECT      0
// Byte 1 fields
`define OBCD_B1_PKG_HI       7
`define OBCD_B1_RST_LEN      6
`define OBCD_B1_SRC_HI       5
`define OBCD_B1_SRC_LO       4
`define OBCD_B1_RANGE_HI     3
`define OBCD_B1_RANGE_LO     1
`define OBCD_B1_DOUBLER      0
// Codes
`define OBCD_VD_OFF          2'h3
`define OBCD_SRC_RESONATOR   2'h0
`define OBCD_SRC_RESERVED    2'h1
`define OBCD_SRC_INTERNAL_RC 2'h2
`define OBCD_RANGE_2_4MHZ    3'h1
`define OBCD_RANGE_MAX       3'h3
`define OBCD_PKG_44          2'h0
// Reset phase lengths in cycles
`define OBCD_RST_LONG        4096
`define OBCD_RST_SHORT       256
// Register map
`define OBCD_REG_OPT0        8'h00
`define OBCD_REG_OPT1        8'h04
`define OBCD_REG_STATUS      8'h08
`define OBCD_REG_CTRL        8'h0C
`define OBCD_CTRL_WDOG_EN    0
`define OBCD_CTRL_CLR_HALT   1

`endif

// ---- obcd_pkg.sv ----
// Types shared by the option decoder modules.
// Assumes obcd_defs.svh for all numeric constants.
package obcd_pkg;
  typedef enum logic [2:0] {
    OBCD_LOAD,
    OBCD_RESET,
    OBCD_RUN,
    OBCD_HALT,
    OBCD_WAKE,
    OBCD_ERASE
  } obcd_phase_e;
endpackage : obcd_pkg

// ---- obcd_cycle_timer.sv ----
// Down counter that times one reset or halt-exit phase.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
`default_nettype none
module obcd_cycle_timer #(
  parameter int W = 13
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] length,
  // Status
  output logic              busy,
  output logic              done
);
  typedef struct packed {
    logic         busy;
    logic [W-1:0] cnt;
  } obcd_timer_s;

  obcd_timer_s st;
  obcd_timer_s next_st;

  initial begin
    if (W < 2) $error("obcd_cycle_timer: W too small");
  end

  always_comb begin
    next_st = st;
    if (start) begin
      next_st.busy = 1'b1;
      next_st.cnt  = length - {{(W-1){1'b0}}, 1'b1};
    end else if (st.busy) begin
      if (st.cnt == '0) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.cnt = st.cnt - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.busy && (st.cnt == '0);
endmodule : obcd_cycle_timer
`default_nettype wire

// ---- obcd_prog_tool.sv ----
// Model of the programming tool that sets the option bytes.
// Assumes the bench calls its tasks after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
`include "obcd_defs.svh"
module obcd_prog_tool (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Option content and erase request
  output logic [7:0]      opt_byte0,
  output logic [7:0]      opt_byte1,
  output logic            opt_erased,
  output logic            option_erase_req
);
  initial begin
    opt_byte0        = 8'h00;
    opt_byte1        = 8'h00;
    opt_erased       = 1'b1;
    option_erase_req = 1'b0;
  end

  // Only reachable while the device is held in reset
  task automatic program_bytes(input logic [7:0] b0, input logic [7:0] b1);
    @(posedge clk);
    if (!reset_n) begin
      opt_byte0  <= {b0[7:3], `OBCD_RESERVED_DEF, b0[1:0]};
      opt_byte1  <= b1;
      opt_erased <= 1'b0;
    end
  endtask : program_bytes

  // Erased flag wins; bytes carry junk so the flag alone must decide
  task automatic erase_content();
    @(posedge clk);
    opt_byte0  <= 8'h00;
    opt_byte1  <= 8'h00;
    opt_erased <= 1'b1;
  endtask : erase_content

  // Deliberate disturbance while running, to be ignored by the device
  task automatic glitch_bytes(input logic [7:0] b0, input logic [7:0] b1);
    @(posedge clk);
    opt_byte0 <= b0;
    opt_byte1 <= b1;
  endtask : glitch_bytes

  task automatic request_erase();
    @(posedge clk);
    option_erase_req <= 1'b1;
    @(posedge clk);
    option_erase_req <= 1'b0;
  endtask : request_erase
endmodule : obcd_prog_tool
`default_nettype wire

// ---- obcd_option_decoder_tb.sv ----
// Self-checking bench for the option byte decoder.
// Assumes short reset phases: 16 cycles long, 8 cycles short.
`timescale 1ns/1ps
`default_nettype none
`include "obcd_defs.svh"
module obcd_option_decoder_tb;
  import obcd_pkg::*;
  localparam int          LONG_N  = 16;
  localparam int          SHORT_N = 8;
  localparam logic [47:0] PADS_44 = 48'h0000_F000_00F0;
  logic        clk = 1'b0, reset_n = 1'b0, opt_erased, option_erase_req;
  logic        halt_entry, halt_wake, user_erase_done, reg_wr, reg_rd;
  logic [7:0]  opt_byte0, opt_byte1, reg_addr, reg_wdata, reg_rdata, d;
  logic        core_reset_n, core_stall, user_erase_start, option_erase_grant;
  logic        wdog_enable, wdog_halt_reset_sel, clock_guard_enable, package_is_44;
  logic        low_supply_detector, aux_supply_detector, readout_block, flash_write_block;
  logic        range_low_power, range_medium_power, range_medium_speed, range_high_speed;
  logic        doubler_enable, config_warning;
  logic [1:0]  voltage_detect_sel, clock_source_type;
  logic [2:0]  oscillator_range_sel;
  logic [47:0] pad_hold_pullup;
  int          n_fail = 0, check_count = 0, cyc = 0, n, i;
  logic [7:0]  t0 [4] = '{8'h04, 8'h8E, 8'hD7, 8'h5D};
  logic [7:0]  t1 [4] = '{8'h02, 8'hE5, 8'h77, 8'h51};

  always #2 clk = ~clk;

  obcd_prog_tool u_obcd_prog_tool (.clk(clk), .reset_n(reset_n), .opt_byte0(opt_byte0),
    .opt_byte1(opt_byte1), .opt_erased(opt_erased), .option_erase_req(option_erase_req));

  obcd_option_decoder #(.RST_LONG(LONG_N), .RST_SHORT(SHORT_N), .UNBONDED_44(PADS_44))
  u_obcd_option_decoder (.clk(clk), .reset_n(reset_n), .opt_byte0(opt_byte0),
    .opt_byte1(opt_byte1), .opt_erased(opt_erased), .halt_entry(halt_entry),
    .halt_wake(halt_wake), .option_erase_req(option_erase_req),
    .user_erase_done(user_erase_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_reset_n(core_reset_n),
    .core_stall(core_stall), .user_erase_start(user_erase_start),
    .option_erase_grant(option_erase_grant), .wdog_enable(wdog_enable),
    .wdog_halt_reset_sel(wdog_halt_reset_sel), .clock_guard_enable(clock_guard_enable),
    .low_supply_detector(low_supply_detector), .aux_supply_detector(aux_supply_detector),
    .voltage_detect_sel(voltage_detect_sel), .readout_block(readout_block),
    .flash_write_block(flash_write_block), .package_is_44(package_is_44),
    .pad_hold_pullup(pad_hold_pullup), .clock_source_type(clock_source_type),
    .oscillator_range_sel(oscillator_range_sel), .range_low_power(range_low_power),
    .range_medium_power(range_medium_power), .range_medium_speed(range_medium_speed),
    .range_high_speed(range_high_speed), .doubler_enable(doubler_enable),
    .config_warning(config_warning));

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // Hang guard: whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("ERROR %0t run did not complete", $time);
      tally_and_finish();
    end
  end

  task automatic chk_eq(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_eq

  task automatic chk_range(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_range

  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe edge
  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_read

  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) halt_entry <= 1'b1;
    else if (k == 1) halt_wake <= 1'b1;
    else user_erase_done <= 1'b1;
    @(posedge clk);
    halt_entry      <= 1'b0;
    halt_wake       <= 1'b0;
    user_erase_done <= 1'b0;
  endtask : pulse

  function automatic logic hit(input int k);
    case (k)
      0: return core_reset_n === 1'b0;
      1: return core_reset_n === 1'b1;
      2: return core_stall === 1'b0;
      3: return user_erase_start === 1'b1;
      default: return option_erase_grant === 1'b1;
    endcase
  endfunction : hit

  task automatic wait_out(input int k, output int c);
    c = 0;
    #1;
    while (!hit(k) && c < 5000) begin
      @(posedge clk);
      #1 c++;
    end
  endtask : wait_out

  task automatic check_decode(input logic [7:0] b0, input logic [7:0] b1);
    logic p44, w;
    logic [2:0] r;
    r   = b1[3:1];
    p44 = !b1[7] && !b0[1];
    w   = b1[5:4] == 2'h1 || !b0[2] || (!b0[0] && b0[4:3] != 2'h3)
          || r > 3'h3 || (!b1[0] && (r != 3'h1 || b1[5:4] == 2'h2));
    chk_eq(wdog_halt_reset_sel, b0[7]);
    chk_eq(wdog_enable, !b0[6]);
    chk_eq(clock_guard_enable, !b0[5]);
    chk_eq(voltage_detect_sel, b0[4:3]);
    chk_eq({low_supply_detector, aux_supply_detector}, {2{b0[4:3] != 2'h3}});
    chk_eq({readout_block, flash_write_block}, {2{!b0[0]}});
    chk_eq(package_is_44, p44);
    chk_eq(pad_hold_pullup, p44 ? PADS_44 : 48'h0);
    chk_eq(clock_source_type, b1[5:4]);
    chk_eq(oscillator_range_sel, r);
    chk_eq({range_low_power, range_medium_power, range_medium_speed, range_high_speed},
           {r == 3'h0, r == 3'h1, r == 3'h2, r == 3'h3});
    chk_eq(doubler_enable, !b1[0]);
    chk_eq(config_warning, w);
    reg_read(`OBCD_REG_OPT0, d); chk_eq(d, b0);
    reg_read(`OBCD_REG_OPT1, d); chk_eq(d, b1);
    reg_read(`OBCD_REG_STATUS, d); chk_eq(d[3:1], {p44, w, !b0[6]});
    reg_read(8'h10, d); chk_eq(d, 8'h00);
    if (b0[6]) begin
      reg_write(`OBCD_REG_CTRL, 8'h01);
      @(posedge clk);
      #1 chk_eq(wdog_enable, 1'b1);
      reg_read(`OBCD_REG_CTRL, d); chk_eq(d, 8'h01);
    end
  endtask : check_decode

  task automatic do_run(input logic [7:0] b0, input logic [7:0] b1, input logic ers);
    int c, np;
    np = (ers || b1[6]) ? SHORT_N : LONG_N;
    @(posedge clk);
    reset_n <= 1'b0;
    if (ers) u_obcd_prog_tool.erase_content();
    else u_obcd_prog_tool.program_bytes(b0, b1);
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    wait_out(1, c); chk_range(c, np + 1, np + 3);
    check_decode(ers ? 8'hFF : b0, ers ? 8'hFF : b1);
  endtask : do_run

  initial begin
    {halt_entry, halt_wake, user_erase_done, reg_wr, reg_rd} = 5'h00;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    do_run(8'h00, 8'h00, 1'b1);
    for (i = 0; i < 4; i++) do_run(t0[i], t1[i], 1'b0);
    // Hardware watchdog, no halt reset: stall, then timed wake
    do_run(t0[0], t1[0], 1'b0);
    pulse(0);
    repeat (3) @(posedge clk);
    #1 chk_eq({core_stall, core_reset_n}, 2'h3);
    pulse(1);
    wait_out(2, n); chk_range(n, LONG_N, LONG_N + 3);
    // Protected erase clears user memory first
    u_obcd_prog_tool.request_erase();
    wait_out(3, n); chk_range(n, 0, 0);
    chk_eq(option_erase_grant, 1'b0);
    pulse(2);
    wait_out(4, n); chk_range(n, 0, 0);
    u_obcd_prog_tool.glitch_bytes(8'hFF, 8'hFF);
    check_decode(t0[0], t1[0]);
    // Halt with active watchdog and halt reset selected
    do_run(t0[1], t1[1], 1'b0);
    pulse(0);
    wait_out(0, n); chk_range(n, 0, 0);
    wait_out(1, n); chk_range(n, SHORT_N, SHORT_N + 3);
    reg_read(`OBCD_REG_STATUS, d); chk_eq(d[0], 1'b1);
    reg_write(`OBCD_REG_CTRL, 8'h02);
    reg_read(`OBCD_REG_STATUS, d); chk_eq(d[0], 1'b0);
    reg_read(`OBCD_REG_OPT0, d); chk_eq(d, t0[1]);
    // Unprotected erase grants at once
    do_run(t0[2], t1[2], 1'b0);
    u_obcd_prog_tool.request_erase();
    wait_out(4, n); chk_range(n, 0, 0);
    chk_eq(user_erase_start, 1'b0);
    tally_and_finish();
  end
endmodule : obcd_option_decoder_tb
`default_nettype wire
